// File: src/aaq_edge.sv
`timescale 1ns/100ps
module aaq_edge #(
  parameter int FILT_CYC = aaq_pkg::FILT_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // control
  input wire logic raw,
  input wire logic filt_en,
  input wire logic fall,
  // result
  output logic edge_pls
);
  localparam int CW = $clog2(FILT_CYC + 1);
  logic [CW-1:0] cnt;
  logic lvl;
  logic lvl_d;
  logic armed;

  // with filt_en set, a new level is taken only after it has held for the whole filter time; with it clear, at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      lvl <= 1'b0;
      lvl_d <= 1'b0;
      armed <= 1'b0;
    end else begin
      lvl_d <= lvl;
      armed <= armed || (raw == lvl); // first match of pin and level arms edges
      if (raw == lvl) begin
        cnt <= '0;
      end else if (!filt_en || cnt == CW'(FILT_CYC - 1)) begin
        lvl <= raw;
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // chosen edge of the filtered level; the first level taken after reset is
  // not an edge, so a line that idles high cannot fake a rising edge
  assign edge_pls = armed && (lvl != lvl_d) && (lvl == !fall);
endmodule : aaq_edge

// File: src/aaq_pkg.sv
package aaq_pkg;
  // sample words and channel counts
  localparam int SAMPLE_W = 16;
  localparam int AI_CH = 8;
  localparam int AO_CH = 2;
  localparam int BUF_DEPTH = 1024;
  // timing: clock rate and the derived cycle counts (least times round up)
  localparam int CLK_MHZ = 200;
  localparam int FILT_NS = 1000;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_NS = 10000;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  // calibration reset values: unity gain is 1.0 in Q2.14
  localparam logic [15:0] CAL_GAIN_ONE = 16'h4000;
  localparam logic [15:0] CAL_OFF_ZERO = 16'h0000;
  localparam int CAL_FRAC = 14;

  typedef enum logic [1:0] {AAQ_STOP_COUNT, AAQ_STOP_EXT, AAQ_STOP_SW} aaq_stop_t;

  // one bit per external control line of a path
  typedef struct packed {
    logic start;
    logic stop;
    logic clk;
  } aaq_ext_t;

  typedef struct packed {
    logic start_ext;
    aaq_stop_t stop_sel;
    logic pace_ext;
    aaq_ext_t fall;
    aaq_ext_t filt_en;
    logic cal_user;
    logic [15:0] count;
    logic [23:0] period;
  } aaq_cfg_t;

  typedef struct packed {
    logic [15:0] gain;
    logic signed [15:0] off;
  } aaq_cal_t;

  // gain then offset, saturated to the 16-bit signed range
  function automatic logic [15:0] aaq_apply(input logic [15:0] x, input aaq_cal_t c);
    logic signed [33:0] p;
    p = 34'(($signed({{18{x[15]}}, x}) * $signed({18'h00000, c.gain})) >>> CAL_FRAC);
    p = p + 34'(c.off);
    if (p > 34'sh0_0000_7FFF) begin
      return 16'h7FFF;
    end else if (p < -34'sh0_0000_8000) begin
      return 16'h8000;
    end
    return p[15:0];
  endfunction : aaq_apply
endpackage : aaq_pkg

// File: src/aaq_seq.sv
`timescale 1ns/100ps
module aaq_seq #(
  parameter int NAI = aaq_pkg::AI_CH,
  parameter int NAO = aaq_pkg::AO_CH,
  parameter int DEPTH = aaq_pkg::BUF_DEPTH,
  parameter logic [15:0] FACT_GAIN = aaq_pkg::CAL_GAIN_ONE,
  parameter logic [15:0] FACT_OFF = aaq_pkg::CAL_OFF_ZERO
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // configuration, index 0 input path, 1 output path
  input wire aaq_pkg::aaq_cfg_t ai_cfg,
  input wire aaq_pkg::aaq_cfg_t ao_cfg,
  input wire logic [3:0] ai_nch,
  input wire aaq_pkg::aaq_cal_t ai_cal,
  input wire aaq_pkg::aaq_cal_t ao_cal,
  // software commands, one-cycle pulses
  input wire logic [1:0] sw_start,
  input wire logic [1:0] sw_stop,
  input wire logic flag_clr,
  // isolated external control lines
  input wire aaq_pkg::aaq_ext_t ai_ext,
  input wire aaq_pkg::aaq_ext_t ao_ext,
  // input converter
  output logic adc_conv,
  output logic [2:0] adc_ch,
  input wire logic [15:0] adc_data,
  // output converter
  output logic dac_load,
  output logic dac_ch,
  output logic [15:0] dac_data,
  // host side of the buffers
  input wire logic ai_rd,
  output logic [15:0] ai_rd_data,
  output logic ai_rd_valid,
  input wire logic ao_wr,
  input wire logic [15:0] ao_wr_data,
  output logic ao_full,
  output logic [$clog2(DEPTH):0] ai_level,
  output logic [$clog2(DEPTH):0] ao_level,
  // status
  output logic [1:0] busy,
  output logic [3:0] flags,
  output logic irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int CC = aaq_pkg::CONV_CYC;
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
  typedef enum logic {AAQ_IDLE, AAQ_RUN} aaq_run_t;
  typedef enum logic {AAQ_SC_IDLE, AAQ_SC_CONV} aaq_scan_t;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  aaq_pkg::aaq_cfg_t cfg [2];
  aaq_pkg::aaq_ext_t ext [2];
  aaq_pkg::aaq_ext_t eg [2];
  wire [1:0] tick;
  wire [1:0] smp_done;
  wire [1:0] done_pls;
  aaq_pkg::aaq_cal_t fact_cal;
  aaq_pkg::aaq_cal_t ai_eff;
  aaq_pkg::aaq_cal_t ao_eff;

  assign cfg[0] = ai_cfg;
  assign cfg[1] = ao_cfg;
  assign ext[0] = ai_ext;
  assign ext[1] = ao_ext;
  // factory set stays as the fallback, user set is chosen per path
  assign fact_cal = {FACT_GAIN, FACT_OFF};
  assign ai_eff = ai_cfg.cal_user ? ai_cal : fact_cal;
  assign ao_eff = ao_cfg.cal_user ? ao_cal : fact_cal;

  //////////////////////////////////////////////////////////////////////////
  // per path: edge conditioning, pacing timer, run control
  for (genvar p = 0; p < 2; p++) begin : g_path
    aaq_run_t state;
    logic [23:0] timer;
    logic [15:0] smp_cnt;
    wire start_req;
    wire stop_req;
    wire cnt_hit;

    for (genvar k = 0; k < 3; k++) begin : g_edge
      aaq_edge u_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .raw(ext[p][k]),
        .filt_en(cfg[p].filt_en[k]),
        .fall(cfg[p].fall[k]),
        .edge_pls(eg[p][k])
      );
    end

    // pace source and start/stop decode
    assign tick[p] = (state == AAQ_RUN) &&
        (cfg[p].pace_ext ? eg[p].clk : timer == 24'h000000);
    assign start_req = cfg[p].start_ext ? eg[p].start : sw_start[p];
    assign cnt_hit = cfg[p].stop_sel == aaq_pkg::AAQ_STOP_COUNT && smp_done[p] &&
        smp_cnt + 16'h0001 == cfg[p].count;
    assign stop_req = sw_stop[p] || cnt_hit ||
        (cfg[p].stop_sel == aaq_pkg::AAQ_STOP_EXT && eg[p].stop);
    assign done_pls[p] = state == AAQ_RUN && stop_req;
    assign busy[p] = state == AAQ_RUN;

    // run state, timer reload and sample count
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        state <= AAQ_IDLE;
        timer <= '0;
        smp_cnt <= '0;
      end else begin
        unique case (state)
          AAQ_IDLE: begin
            if (start_req) begin
              state <= AAQ_RUN;
              timer <= cfg[p].period;
              smp_cnt <= '0;
            end
          end
          AAQ_RUN: begin
            if (stop_req) begin
              state <= AAQ_IDLE;
            end
            timer <= (timer == 24'h000000) ? cfg[p].period : timer - 24'h000001;
            if (smp_done[p]) begin
              smp_cnt <= smp_cnt + 16'h0001;
            end
          end
        endcase
      end
    end

    a_sw_start: assert property (state == AAQ_IDLE && !cfg[p].start_ext && sw_start[p]
        |=> state == AAQ_RUN) else $error("software start ignored");
    a_ext_start: assert property (state == AAQ_IDLE && cfg[p].start_ext && eg[p].start
        |=> state == AAQ_RUN) else $error("external start ignored");
    a_sw_stop: assert property (state == AAQ_RUN && sw_stop[p]
        |=> state == AAQ_IDLE && flags[2 + p]) else $error("stop lost");
    a_cnt_stop: assert property (state == AAQ_RUN && cnt_hit
        |=> state == AAQ_IDLE) else $error("count stop missed");
    c_run: cover property (state == AAQ_RUN ##1 state == AAQ_IDLE);
  end

  //////////////////////////////////////////////////////////////////////////
  // input scan: one conversion slot of fixed length per channel
  aaq_scan_t sc;
  logic [11:0] cnt;
  logic [2:0] ch;
  wire [2:0] last_ch = (ai_nch == 4'h0) ? 3'h0 : 3'(ai_nch - 4'h1);
  wire ai_we = sc == AAQ_SC_CONV && cnt == 12'h000;
  assign smp_done[0] = ai_we && ch == last_ch;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sc <= AAQ_SC_IDLE;
      cnt <= '0;
      ch <= '0;
      adc_conv <= 1'b0;
      adc_ch <= '0;
    end else begin
      adc_conv <= 1'b0;
      unique case (sc)
        AAQ_SC_IDLE: begin
          if (tick[0]) begin
            sc <= AAQ_SC_CONV;
            ch <= '0;
            cnt <= 12'(CC - 1);
            adc_conv <= 1'b1;
            adc_ch <= '0;
          end
        end
        AAQ_SC_CONV: begin
          if (cnt != 12'h000) begin
            cnt <= cnt - 12'h001;
          end else if (ch == last_ch) begin
            sc <= AAQ_SC_IDLE;
          end else begin
            ch <= ch + 3'h1;
            cnt <= 12'(CC - 1);
            adc_conv <= 1'b1;
            adc_ch <= ch + 3'h1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // input buffer: scanner fills, host drains
  logic [15:0] ai_mem [DEPTH];
  logic [AW-1:0] ai_wp;
  logic [AW-1:0] ai_rp;
  wire ai_ovf = ai_we && ai_level == FULL;
  wire ai_push = ai_we && !ai_ovf;
  wire ai_pop = ai_rd && ai_level != '0;

  always_ff @(posedge mclk) begin
    if (ai_push) begin
      ai_mem[ai_wp] <= aaq_pkg::aaq_apply(adc_data, ai_eff);
    end
    ai_rd_data <= ai_mem[ai_rp];
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ai_wp <= '0;
      ai_rp <= '0;
      ai_level <= '0;
      ai_rd_valid <= 1'b0;
    end else begin
      ai_wp <= ai_wp + AW'(ai_push);
      ai_rp <= ai_rp + AW'(ai_pop);
      ai_level <= ai_level + (AW + 1)'(ai_push) - (AW + 1)'(ai_pop);
      ai_rd_valid <= ai_pop;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output buffer: host fills, each tick outside a burst drains one word per channel
  logic [15:0] ao_mem [DEPTH];
  logic [AW-1:0] ao_wp;
  logic [AW-1:0] ao_rp;
  logic [1:0] ao_left;
  wire ao_slot = ao_left != 2'h0;
  wire ao_pop = ao_slot && ao_level != '0;
  wire ao_unf = ao_slot && ao_level == '0;
  wire ao_push = ao_wr && !ao_full;
  assign ao_full = ao_level == FULL;
  assign smp_done[1] = tick[1] && !ao_slot;

  always_ff @(posedge mclk) begin
    if (ao_push) begin
      ao_mem[ao_wp] <= ao_wr_data;
    end
  end

  // a tick that lands inside a burst is dropped rather than queued
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ao_wp <= '0;
      ao_rp <= '0;
      ao_level <= '0;
      ao_left <= '0;
      dac_load <= 1'b0;
      dac_ch <= 1'b0;
      dac_data <= '0;
    end else begin
      ao_wp <= ao_wp + AW'(ao_push);
      ao_rp <= ao_rp + AW'(ao_pop);
      ao_level <= ao_level + (AW + 1)'(ao_push) - (AW + 1)'(ao_pop);
      ao_left <= smp_done[1] ? 2'(NAO) : ao_left - 2'(ao_slot);
      dac_load <= ao_pop;
      dac_ch <= 1'(NAO - int'(ao_left));
      dac_data <= aaq_pkg::aaq_apply(ao_mem[ao_rp], ao_eff);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky flags {ao_done, ai_done, ao_err, ai_err}; a set beats a clear
  wire [3:0] set = {done_pls, ao_unf, ai_ovf};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~{4{flag_clr}}) | set;
    end
  end
  assign irq = |flags;

  // cycles since the last conversion start, saturating at one slot
  logic [11:0] gap;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 12'(CC);
    end else begin
      gap <= adc_conv ? 12'h001 : (gap < 12'(CC) ? gap + 12'h001 : gap);
    end
  end

  a_conv_gap: assert property (adc_conv |-> gap == 12'(CC))
    else $error("conversion slot too short");
  a_conv_ch: assert property (adc_conv |-> adc_ch <= last_ch)
    else $error("channel beyond scan");
  a_ai_ovf: assert property (ai_we && ai_level == FULL
      |=> flags[0] && ai_level == FULL - (AW + 1)'($past(ai_pop)))
    else $error("overflow not flagged");
  a_ao_unf: assert property (ao_slot && ao_level == '0 |=> flags[1] && !dac_load)
    else $error("underrun not flagged");
  a_irq_err: assert property (ai_ovf || ao_unf |=> irq)
    else $error("error without interrupt");
  a_ao_burst: assert property (smp_done[1] && ao_level >= 2 |=> ##1 dac_load [*2])
    else $error("output burst incomplete");
  c_scan: cover property (adc_conv && adc_ch == 3'h7);
  c_ovf: cover property (ai_ovf);
  c_dac: cover property (dac_load && dac_ch);
endmodule : aaq_seq

// File: verif/aaq_adc_model.sv
`timescale 1ns/100ps
module aaq_adc_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // conversion request
  input wire logic adc_conv,
  input wire logic [2:0] adc_ch,
  // result
  output logic [15:0] adc_data
);
  int cnt;
  logic [15:0] n;
  ////////////////////////////////////////////////////////////////////////
  // result is held one conversion time, then toggles so a late sample shows
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      n <= 16'h0000;
      adc_data <= 16'h0000;
    end else if (adc_conv) begin
      adc_data <= 16'hA000 ^ {5'h00, adc_ch, 8'h00} ^ n;
      n <= n + 16'h0001;
      cnt <= 1;
    end else if (cnt == aaq_pkg::CONV_CYC) begin
      adc_data <= ~adc_data;
    end else if (cnt != 0) begin
      cnt <= cnt + 1;
    end
  end
endmodule : aaq_adc_model

// File: verif/analog_acq_sequencer_tb_top.sv
`timescale 1ns/100ps
module analog_acq_sequencer_tb_top;
  logic mclk, rst_n, flag_clr, adc_conv, dac_load, dac_ch, ai_rd, ai_rd_valid;
  logic ao_wr, ao_full, irq;
  aaq_pkg::aaq_cfg_t ai_cfg, ao_cfg;
  aaq_pkg::aaq_cal_t ai_cal, ao_cal;
  aaq_pkg::aaq_ext_t ai_ext, ao_ext;
  logic [3:0] ai_nch, flags;
  logic [1:0] sw_start, sw_stop, busy;
  logic [2:0] adc_ch;
  logic [15:0] adc_data, dac_data, ai_rd_data, ao_wr_data;
  logic [10:0] ai_level, ao_level;
  logic [15:0] w [4];
  int err_count, comparisons, seed, k, j, lastc, nconv;

  aaq_seq u_dut (.mclk(mclk), .rst_n(rst_n), .ai_cfg(ai_cfg), .ao_cfg(ao_cfg), .ai_nch(ai_nch),
    .ai_cal(ai_cal), .ao_cal(ao_cal), .sw_start(sw_start), .sw_stop(sw_stop),
    .flag_clr(flag_clr), .ai_ext(ai_ext), .ao_ext(ao_ext), .adc_conv(adc_conv),
    .adc_ch(adc_ch), .adc_data(adc_data), .dac_load(dac_load), .dac_ch(dac_ch),
    .dac_data(dac_data), .ai_rd(ai_rd), .ai_rd_data(ai_rd_data), .ai_rd_valid(ai_rd_valid),
    .ao_wr(ao_wr), .ao_wr_data(ao_wr_data), .ao_full(ao_full), .ai_level(ai_level),
    .ao_level(ao_level), .busy(busy), .flags(flags), .irq(irq));
  aaq_adc_model u_adc (.mclk(mclk), .rst_n(rst_n), .adc_conv(adc_conv), .adc_ch(adc_ch),
    .adc_data(adc_data));
  ////////////////////////////////////////////////////////////////////////
  // clock, 200 MHz
  always #2.5 mclk = ~mclk;

  // expectations, written apart from the design so a shared slip cannot hide
  function automatic logic [15:0] cal(logic [15:0] x, logic [15:0] g, logic [15:0] o);
    longint p;
    p = (longint'($signed(x)) * longint'(g)) >>> 14;
    p = p + longint'($signed(o));
    if (p > 32767) return 16'h7FFF;
    if (p < -32768) return 16'h8000;
    return p[15:0];
  endfunction : cal
  function automatic logic [15:0] ai_exp(int n);
    return 16'hA000 ^ {5'h00, 3'(n % 2), 8'h00} ^ 16'(n);
  endfunction : ai_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic results;
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs about 10k cycles
  initial begin
    repeat (40000) @(posedge mclk);
    err_count++;
    results();
  end

  initial begin
    seed = 32'h2a97;
    mclk = 1'b0;
    rst_n = 1'b0;
    {ai_cfg, ao_cfg, sw_start, sw_stop, flag_clr, ai_ext, ai_rd, ao_wr, ao_wr_data} = '0;
    ai_nch = 4'h2;
    ai_cal = '{gain: 16'h8000, off: 16'h0100}; // unused: factory set selected
    ao_cal = '{gain: 16'h2000, off: 16'h0100};
    ao_ext = '{start: 1'b1, stop: 1'b0, clk: 1'b0};
    ai_cfg.count = 16'h0002;
    ai_cfg.period = 24'h00000A;
    ao_cfg.period = 24'h000014;
    ao_cfg.start_ext = 1'b1;
    ao_cfg.fall.start = 1'b1;
    ao_cfg.filt_en.start = 1'b1;
    tick(2);
    rst_n <= 1'b1;
    #1 check({busy, flags, irq}, 0);
    // external falling start: a short glitch is filtered, a long low starts
    tick(300);
    ao_ext.start <= 1'b0;
    tick(50);
    ao_ext.start <= 1'b1;
    tick(300);
    #1 check(busy[1], 0);
    tick(1);
    ao_ext.start <= 1'b0;
    tick(210);
    #1 check(busy[1], 1);
    tick(60);
    #1 check(flags[1], 1);
    check(irq, 1);
    tick(1);
    sw_stop <= 2'b10;
    tick(1);
    sw_stop <= 2'b00;
    tick(3);
    #1 check(busy[1], 0);
    tick(1);
    flag_clr <= 1'b1;
    tick(1);
    flag_clr <= 1'b0;
    tick(2);
    #1 check({flags, irq}, 0);
    // output burst with user calibration, stopped by count
    tick(1);
    ao_cfg.start_ext <= 1'b0;
    ao_cfg.cal_user <= 1'b1;
    ao_cfg.count <= 16'h0002;
    for (k = 0; k < 4; k++) begin
      w[k] = 16'($random(seed));
      ao_wr <= 1'b1;
      ao_wr_data <= w[k];
      tick(1);
    end
    ao_wr <= 1'b0;
    tick(1);
    #1 check(ao_level, 4);
    check(ao_full, 0);
    tick(1);
    sw_start <= 2'b10;
    tick(1);
    sw_start <= 2'b00;
    k = 0;
    for (j = 0; j < 200; j++) begin
      tick(1);
      #1 if (dac_load === 1'b1 && k < 4) begin
        check(dac_ch, k % 2);
        check(dac_data, cal(w[k], 16'h2000, 16'h0100));
        k++;
      end
    end
    check(k, 4);
    check({busy[1], flags[3]}, 1);
    // input scan of two channels, two scans by count
    tick(1);
    sw_start <= 2'b01;
    tick(1);
    sw_start <= 2'b00;
    lastc = -1;
    nconv = 0;
    // busy is only settled a step after the edge that launches it
    #1;
    for (j = 0; j < 12000 && busy[0] !== 1'b0; j++) begin
      tick(1);
      #1 if (adc_conv === 1'b1) begin
        if (nconv % 2 == 1) check(j - lastc, aaq_pkg::CONV_CYC);
        check(adc_ch, nconv % 2);
        lastc = j;
        nconv++;
      end
    end
    check(nconv, 4);
    tick(3);
    #1 check(ai_level, 4);
    check(flags[2], 1);
    for (k = 0; k < 5; k++) begin
      tick(1);
      ai_rd <= 1'b1;
      tick(1);
      ai_rd <= 1'b0;
      #1 check(ai_rd_valid, k < 4);
      if (k < 4) check(ai_rd_data, ai_exp(k));
    end
    // output paced by a rising external clock, ended by a rising external stop
    tick(1);
    ao_cfg.pace_ext <= 1'b1;
    ao_cfg.stop_sel <= aaq_pkg::AAQ_STOP_EXT;
    ao_cfg.fall <= '0;
    ao_cfg.filt_en <= '0;
    for (k = 0; k < 2; k++) begin
      w[k] = 16'($random(seed));
      ao_wr <= 1'b1;
      ao_wr_data <= w[k];
      tick(1);
    end
    ao_wr <= 1'b0;
    flag_clr <= 1'b1;
    sw_start <= 2'b10;
    tick(1);
    sw_start <= 2'b00;
    flag_clr <= 1'b0;
    tick(2);
    ao_ext.clk <= 1'b1;
    k = 0;
    for (j = 0; j < 10; j++) begin
      tick(1);
      #1 if (dac_load === 1'b1) begin
        check(dac_ch, k % 2);
        check(dac_data, cal(w[k % 2], 16'h2000, 16'h0100));
        k++;
      end
    end
    check(k, 2);
    tick(1);
    ao_ext.stop <= 1'b1;
    tick(4);
    #1 check({busy[1], flags[3]}, 1);
    results();
  end
endmodule : analog_acq_sequencer_tb_top
